//--- core/rls_cfg.svh
`ifndef RLS_CFG_SVH
`define RLS_CFG_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index).
// ----------------------------------------------------------------
`define RLS_IDX_W       10
`define RLS_IDX_LSEL    10'h0DD
`define RLS_IDX_LID     10'h0E3
`define RLS_IDX_STATE   10'h0E4
`define RLS_IDX_FSYNC   10'h0E5
`define RLS_IDX_DSYNC   10'h0E6
`define RLS_IDX_ISTAT   10'h1F0
`define RLS_IDX_IMASK   10'h1F1

// ----------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------
`define RLS_LID_RST     16'h0020
`define RLS_STATE_RST   16'h0000
`define RLS_LSEL_RST    4'h0

// ----------------------------------------------------------------
// Field positions and widths.
// ----------------------------------------------------------------
`define RLS_LSEL_HI     3
`define RLS_LSEL_LO     0
`define RLS_LSEL_TOG    4
`define RLS_LID_FLOSS   7
`define RLS_LID_DLOSS   6
`define RLS_LID_REF     5
`define RLS_LID_NUM_HI  4
`define RLS_LID_NUM_LO  0
`define RLS_LID_USED    8
`define RLS_ST_LEN_HI   5
`define RLS_ST_LEN_LO   4
`define RLS_ST_FST_HI   3
`define RLS_ST_FST_LO   2
`define RLS_ST_DST_HI   1
`define RLS_ST_DST_LO   0
`define RLS_ST_USED     6
`define RLS_ID_W        5
`define RLS_F2_W        2
`define RLS_DST_UNUSED  2'b11
`define RLS_IRQ_W       3
`define RLS_IRQ_SNAP    0
`define RLS_IRQ_FSYNC   1
`define RLS_IRQ_DSYNC   2

`endif

//--- core/rls_irq.sv
`timescale 1ns/1ps
`include "rls_cfg.svh"

module rls_irq
  import rls_pkg::*;
#(
  parameter int W = `RLS_IRQ_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] ev_in,
  input  wire logic         w1c_in,
  input  wire logic         mask_wr_in,
  input  wire logic [W-1:0] wdata_in,
  output logic      [W-1:0] stat_out,
  output logic      [W-1:0] mask_out,
  output logic              irq_out
);

  logic [W-1:0] stat_q, stat_d;
  logic [W-1:0] mask_q, mask_d;
  logic         irq_q, irq_d;

  // Set beats clear so an event landing on a clear is kept.
  always_comb begin
    stat_d = (stat_q & ~(w1c_in ? wdata_in : '0)) | ev_in;
    mask_d = mask_wr_in ? wdata_in : mask_q;
    irq_d  = |(stat_d & mask_d);
  end

  // Registers; the clock enable freezes everything.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else if (ce_in) begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  assign stat_out = stat_q;
  assign mask_out = mask_q;
  assign irq_out  = irq_q;

  chk_set_wins_clear: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) ce_in && w1c_in && ev_in[0] |=> stat_q[0])
    else $error("Event lost against a clear.");

endmodule

//--- core/rls_pkg.sv
package rls_pkg;

  // ----------------------------------------------------------------
  // Shared types.
  // ----------------------------------------------------------------
  typedef logic [15:0] rls_word_t;
  typedef logic [3:0]  rls_link_t;

  // Inverse-mux frame state codes as reported to software.
  typedef enum logic [1:0] {
    RLS_F_HUNT    = 2'b00,
    RLS_F_PRESYNC = 2'b01,
    RLS_F_SYNC    = 2'b10,
    RLS_F_STUFF   = 2'b11
  } rls_fstate_e;

  // Cell delineation state codes; the fourth code is never shown.
  typedef enum logic [1:0] {
    RLS_D_HUNT    = 2'b00,
    RLS_D_PRESYNC = 2'b01,
    RLS_D_SYNC    = 2'b10
  } rls_dstate_e;

endpackage

//--- core/rls_regs.sv
// Functional notes
// [R1] Link select field bits 3:0 picks the link the snapshots describe.
// [R2] Snapshots reload only when a link select write completes.
// [R3] Identity bits 15:8 and state bits 15:6 read zero.
// [R4] Identity bit 7 shows the selected link's frame loss defect.
// [R5] Identity bit 6 shows the selected link's delineation loss defect.
// [R6] Identity bit 5 is one when the link is the group reference.
// [R7] Identity bits 4:0 hold the selected link's identifier number.
// [R8] Identity snapshot resets to 0020 hex.
// [R9] State bits 5:4 show the selected link's frame length.
// [R10] State bits 3:2 give frame state: hunt, presync, sync, stuffed.
// [R11] State bits 1:0 give delineation state; code 11 never appears.
// [R12] Frame sync status bit n follows link n live.
// [R13] Delineation sync status bit n follows link n live.
// [R14] Reads change no stored state anywhere.
`timescale 1ns/1ps
`include "rls_cfg.svh"

module rls_regs
  import rls_pkg::*;
#(
  parameter int NL = 16
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     ce_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  output logic                          irq_out,
  input  wire logic [NL*`RLS_ID_W-1:0]  link_id_in,
  input  wire logic [NL-1:0]            ref_link_in,
  input  wire logic [NL-1:0]            frame_loss_defect_in,
  input  wire logic [NL-1:0]            delineation_loss_defect_in,
  input  wire logic [NL*`RLS_F2_W-1:0]  frame_len_in,
  input  wire logic [NL*`RLS_F2_W-1:0]  frame_state_in,
  input  wire logic [NL*`RLS_F2_W-1:0]  delin_state_in,
  input  wire logic [NL-1:0]            frame_sync_in,
  input  wire logic [NL-1:0]            delin_sync_in
);

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  logic [`RLS_IDX_W-1:0] idx;
  logic                  aligned;
  logic                  hit;
  logic                  setup;
  logic                  access;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  wr_lsel;
  logic                  wr_istat;
  logic                  wr_imask;

  // The slave never inserts wait states; only a frozen clock stalls it.
  assign pready_out = ce_in;
  assign idx        = paddr_in[11:2];
  assign aligned    = (paddr_in[1:0] == 2'b00);
  assign setup      = psel_in && !penable_in && ce_in;
  assign access     = psel_in && penable_in && ce_in;
  assign wr_acc     = access && pwrite_in;
  assign rd_acc     = access && !pwrite_in;

  // Write strobes for the few writable words.
  assign wr_lsel  = wr_acc && aligned && (idx == `RLS_IDX_LSEL);
  assign wr_istat = wr_acc && aligned && (idx == `RLS_IDX_ISTAT);
  assign wr_imask = wr_acc && aligned && (idx == `RLS_IDX_IMASK);

  // Address map membership; anything else answers with an error.
  always_comb begin
    hit = 1'b0;
    if (aligned) begin
      unique case (idx)
        `RLS_IDX_LSEL,
        `RLS_IDX_LID,
        `RLS_IDX_STATE,
        `RLS_IDX_FSYNC,
        `RLS_IDX_DSYNC,
        `RLS_IDX_ISTAT,
        `RLS_IDX_IMASK: hit = 1'b1;
        default:        hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link select register.
  // ----------------------------------------------------------------
  rls_link_t lsel_q, lsel_d;
  logic      tog_q, tog_d;

  // [R1] Link select store.
  // The toggle bit flips on every completed write, whatever the word,
  // so software can tell that a write really landed.
  always_comb begin
    lsel_d = lsel_q;
    tog_d  = tog_q;
    if (wr_lsel) begin
      lsel_d = pwdata_in[`RLS_LSEL_HI:`RLS_LSEL_LO];
    end
    if (wr_acc) begin
      tog_d = ~tog_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lsel_q <= `RLS_LSEL_RST;
      tog_q  <= 1'b0;
    end else if (ce_in) begin
      lsel_q <= lsel_d;
      tog_q  <= tog_d;
    end
  end

  // ----------------------------------------------------------------
  // Snapshot capture.
  // ----------------------------------------------------------------
  rls_word_t lid_w;
  rls_word_t state_w;

  // [R2] Load with new link.
  // The load uses the link number being written, not the old one, so
  // the snapshot matches the select value software just set.
  rls_snap #(
    .NL (NL)
  ) u_snap (
    .clk_in                     (clk_in),
    .rst_n_in                   (rst_n_in),
    .ce_in                      (ce_in),
    .load_in                    (wr_lsel),
    .sel_in                     (pwdata_in[`RLS_LSEL_HI:`RLS_LSEL_LO]),
    .link_id_in                 (link_id_in),
    .ref_link_in                (ref_link_in),
    .frame_loss_defect_in       (frame_loss_defect_in),
    .delineation_loss_defect_in (delineation_loss_defect_in),
    .frame_len_in               (frame_len_in),
    .frame_state_in             (frame_state_in),
    .delin_state_in             (delin_state_in),
    .lid_out                    (lid_w),
    .state_out                  (state_w)
  );

  // ----------------------------------------------------------------
  // Events and interrupt.
  // ----------------------------------------------------------------
  logic [NL-1:0]         fsync_prev_q, fsync_prev_d;
  logic [NL-1:0]         dsync_prev_q, dsync_prev_d;
  logic [`RLS_IRQ_W-1:0] ev;
  logic [`RLS_IRQ_W-1:0] istat_w;
  logic [`RLS_IRQ_W-1:0] imask_w;

  // Remember the last sync levels to spot any link changing state.
  always_comb begin
    fsync_prev_d = frame_sync_in;
    dsync_prev_d = delin_sync_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fsync_prev_q <= '0;
      dsync_prev_q <= '0;
    end else if (ce_in) begin
      fsync_prev_q <= fsync_prev_d;
      dsync_prev_q <= dsync_prev_d;
    end
  end

  // Event sources: snapshot loaded, any frame or delineation change.
  always_comb begin
    ev                 = '0;
    ev[`RLS_IRQ_SNAP]  = wr_lsel;
    ev[`RLS_IRQ_FSYNC] = |(frame_sync_in ^ fsync_prev_q);
    ev[`RLS_IRQ_DSYNC] = |(delin_sync_in ^ dsync_prev_q);
  end

  rls_irq #(
    .W (`RLS_IRQ_W)
  ) u_irq (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .ev_in      (ev),
    .w1c_in     (wr_istat),
    .mask_wr_in (wr_imask),
    .wdata_in   (pwdata_in[`RLS_IRQ_W-1:0]),
    .stat_out   (istat_w),
    .mask_out   (imask_w),
    .irq_out    (irq_out)
  );

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  rls_word_t   rd_word;
  logic [31:0] prdata_q, prdata_d;
  logic        err_q, err_d;

  // [R14] Side-effect free reads.
  // Read selection is pure muxing; no read strobe reaches any state.
  always_comb begin
    rd_word = '0;
    if (aligned) begin
      unique case (idx)
        `RLS_IDX_LSEL: begin
          rd_word[`RLS_LSEL_HI:`RLS_LSEL_LO] = lsel_q;
          rd_word[`RLS_LSEL_TOG]              = tog_q;
        end
        `RLS_IDX_LID:   rd_word = lid_w;
        `RLS_IDX_STATE: rd_word = state_w;
        // [R12] Live frame sync.
        `RLS_IDX_FSYNC: rd_word[NL-1:0] = frame_sync_in;
        // [R13] Live delineation sync.
        `RLS_IDX_DSYNC: rd_word[NL-1:0] = delin_sync_in;
        `RLS_IDX_ISTAT: rd_word[`RLS_IRQ_W-1:0] = istat_w;
        `RLS_IDX_IMASK: rd_word[`RLS_IRQ_W-1:0] = imask_w;
        default:        rd_word = '0;
      endcase
    end
  end

  // Read data and error are caught in the setup cycle so that both
  // leave flip-flops; live bits are therefore one cycle old at the
  // access edge, which is invisible at bus speed.
  always_comb begin
    prdata_d = prdata_q;
    err_d    = err_q;
    if (setup) begin
      prdata_d = {16'h0000, rd_word};
      err_d    = !hit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
    end else if (ce_in) begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  assign prdata_out  = prdata_q;
  assign pslverr_out = err_q;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  logic rd_fsync;
  logic rd_dsync;
  assign rd_fsync = setup && !pwrite_in && aligned && idx == `RLS_IDX_FSYNC;
  assign rd_dsync = setup && !pwrite_in && aligned && idx == `RLS_IDX_DSYNC;

  chk_lsel_write: assert property (@(posedge clk_in) // [R1]
    disable iff (!rst_n_in)
    wr_lsel |=> lsel_q == $past(pwdata_in[`RLS_LSEL_HI:`RLS_LSEL_LO]))
    else $error("Link select not stored.");

  chk_fsync_live: assert property (@(posedge clk_in) // [R12]
    disable iff (!rst_n_in)
    rd_fsync |=> prdata_out[NL-1:0] == $past(frame_sync_in)
             && prdata_out[31:NL] == '0)
    else $error("Frame sync read wrong.");

  chk_dsync_live: assert property (@(posedge clk_in) // [R13]
    disable iff (!rst_n_in)
    rd_dsync |=> prdata_out[NL-1:0] == $past(delin_sync_in)
             && prdata_out[31:NL] == '0)
    else $error("Delineation sync read wrong.");

  chk_read_clean: assert property (@(posedge clk_in) // [R14]
    disable iff (!rst_n_in)
    rd_acc |=> $stable(lsel_q) && $stable(tog_q) && $stable(lid_w)
           && $stable(state_w) && $stable(imask_w))
    else $error("A read changed stored state.");

  chk_unmapped_err: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    setup && !hit |=> pslverr_out && prdata_out == '0)
    else $error("Unmapped access not refused.");

  chk_irq_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && wr_imask && pwdata_in[`RLS_IRQ_W-1:0] == '0
      |=> !irq_out)
    else $error("Interrupt high with all masked.");

  cov_fsync_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_fsync ##1 prdata_out[0]);
  cov_irq_seen: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(irq_out));
  cov_err_seen: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    access && pslverr_out);
  cov_select_load: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_lsel ##1 rd_acc);

endmodule

//--- core/rls_snap.sv
`timescale 1ns/1ps
`include "rls_cfg.svh"

module rls_snap
  import rls_pkg::*;
#(
  parameter int NL = 16
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     ce_in,
  input  wire logic                     load_in,
  input  wire rls_link_t                sel_in,
  input  wire logic [NL*`RLS_ID_W-1:0]  link_id_in,
  input  wire logic [NL-1:0]            ref_link_in,
  input  wire logic [NL-1:0]            frame_loss_defect_in,
  input  wire logic [NL-1:0]            delineation_loss_defect_in,
  input  wire logic [NL*`RLS_F2_W-1:0]  frame_len_in,
  input  wire logic [NL*`RLS_F2_W-1:0]  frame_state_in,
  input  wire logic [NL*`RLS_F2_W-1:0]  delin_state_in,
  output rls_word_t                     lid_out,
  output rls_word_t                     state_out
);

  rls_word_t               lid_q, lid_d;
  rls_word_t               st_q, st_d;
  logic [`RLS_ID_W-1:0]    s_id;
  logic [`RLS_F2_W-1:0]    s_len;
  logic [`RLS_F2_W-1:0]    s_draw;
  rls_fstate_e             s_fst;
  rls_dstate_e             s_dst;
  logic                    s_ref, s_floss, s_dloss, load_ce;

  // Pick the selected link's values from the control protocol cells.
  assign s_id    = link_id_in[sel_in*`RLS_ID_W +: `RLS_ID_W];
  assign s_len   = frame_len_in[sel_in*`RLS_F2_W +: `RLS_F2_W];
  assign s_fst   = rls_fstate_e'(
                     frame_state_in[sel_in*`RLS_F2_W +: `RLS_F2_W]);
  assign s_draw  = delin_state_in[sel_in*`RLS_F2_W +: `RLS_F2_W];
  assign s_ref   = ref_link_in[sel_in];
  assign s_floss = frame_loss_defect_in[sel_in];
  assign s_dloss = delineation_loss_defect_in[sel_in];
  assign load_ce = load_in && ce_in;

  // [R11] Unused code masked.
  // A stray unused code from the machine is shown as hunt.
  assign s_dst = (s_draw == `RLS_DST_UNUSED) ? RLS_D_HUNT
                                             : rls_dstate_e'(s_draw);

  // [R2] Load on write.
  always_comb begin
    lid_d = lid_q;
    st_d  = st_q;
    if (load_in) begin
      // [R3] High bits zero.
      lid_d = '0;
      st_d  = '0;
      // [R4] Frame loss bit.
      lid_d[`RLS_LID_FLOSS] = s_floss;
      // [R5] Delineation loss bit.
      lid_d[`RLS_LID_DLOSS] = s_dloss;
      // [R6] Reference link flag.
      lid_d[`RLS_LID_REF] = s_ref;
      // [R7] Link identifier field.
      lid_d[`RLS_LID_NUM_HI:`RLS_LID_NUM_LO] = s_id;
      // [R9] Frame length field.
      st_d[`RLS_ST_LEN_HI:`RLS_ST_LEN_LO] = s_len;
      // [R10] Frame state field.
      st_d[`RLS_ST_FST_HI:`RLS_ST_FST_LO] = s_fst;
      st_d[`RLS_ST_DST_HI:`RLS_ST_DST_LO] = s_dst;
    end
  end

  // [R8] Reset snapshot values.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lid_q <= `RLS_LID_RST;
      st_q  <= `RLS_STATE_RST;
    end else if (ce_in) begin
      lid_q <= lid_d;
      st_q  <= st_d;
    end
  end

  assign lid_out   = lid_q;
  assign state_out = st_q;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  chk_snap_hold: assert property (@(posedge clk_in) // [R2]
    disable iff (!rst_n_in)
    !load_ce |=> $stable(lid_q) && $stable(st_q))
    else $error("Snapshot changed without a load.");
  chk_high_zero: assert property (@(posedge clk_in) // [R3]
    disable iff (!rst_n_in)
    lid_q[15:`RLS_LID_USED] == '0 && st_q[15:`RLS_ST_USED] == '0)
    else $error("Unused snapshot bits not zero.");
  chk_floss_load: assert property (@(posedge clk_in) // [R4]
    disable iff (!rst_n_in)
    load_ce |=> lid_q[`RLS_LID_FLOSS] == $past(s_floss))
    else $error("Frame loss bit wrong.");
  chk_dloss_load: assert property (@(posedge clk_in) // [R5]
    disable iff (!rst_n_in)
    load_ce |=> lid_q[`RLS_LID_DLOSS] == $past(s_dloss))
    else $error("Delineation loss bit wrong.");
  chk_ref_load: assert property (@(posedge clk_in) // [R6]
    disable iff (!rst_n_in)
    load_ce |=> lid_q[`RLS_LID_REF] == $past(s_ref))
    else $error("Reference flag wrong.");
  chk_id_load: assert property (@(posedge clk_in) // [R7]
    disable iff (!rst_n_in)
    load_ce |=> lid_q[`RLS_LID_NUM_HI:`RLS_LID_NUM_LO] == $past(s_id))
    else $error("Link identifier wrong.");
  chk_lid_reset: assert property (@(posedge clk_in) // [R8]
    !rst_n_in |=> lid_q == `RLS_LID_RST)
    else $error("Identity snapshot reset value wrong.");
  chk_len_load: assert property (@(posedge clk_in) // [R9]
    disable iff (!rst_n_in)
    load_ce |=> st_q[`RLS_ST_LEN_HI:`RLS_ST_LEN_LO] == $past(s_len))
    else $error("Frame length wrong.");
  chk_fstate_load: assert property (@(posedge clk_in) // [R10]
    disable iff (!rst_n_in)
    load_ce |=> st_q[`RLS_ST_FST_HI:`RLS_ST_FST_LO] == $past(s_fst))
    else $error("Frame state wrong.");
  chk_dstate_legal: assert property (@(posedge clk_in) // [R11]
    disable iff (!rst_n_in)
    st_q[`RLS_ST_DST_HI:`RLS_ST_DST_LO] != `RLS_DST_UNUSED)
    else $error("Unused delineation code shown.");
  cov_snap_load: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    load_ce ##1 lid_q[`RLS_LID_REF] == 1'b0);

endmodule

//--- verif/test_rls_regs.sv
`timescale 1ns/1ps
`include "rls_cfg.svh"

module test_rls_regs;

  // ----------------------------------------------------------------
  // Bench signals.
  // ----------------------------------------------------------------
  logic        clk_in;
  logic        rst_n_in;
  logic        ce_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  logic [79:0] link_id_in;
  logic [15:0] ref_link_in;
  logic [15:0] frame_loss_defect_in;
  logic [15:0] delineation_loss_defect_in;
  logic [31:0] frame_len_in;
  logic [31:0] frame_state_in;
  logic [31:0] delin_state_in;
  logic [15:0] frame_sync_in;
  logic [15:0] delin_sync_in;
  logic [31:0] rd;
  logic        er;
  int          error_cnt;
  int          num_checks;
  int          cyc;

  rls_regs #(.NL(16)) dut_u (
    .clk_in                     (clk_in),
    .rst_n_in                   (rst_n_in),
    .ce_in                      (ce_in),
    .psel_in                    (psel_in),
    .penable_in                 (penable_in),
    .pwrite_in                  (pwrite_in),
    .paddr_in                   (paddr_in),
    .pwdata_in                  (pwdata_in),
    .prdata_out                 (prdata_out),
    .pready_out                 (pready_out),
    .pslverr_out                (pslverr_out),
    .irq_out                    (irq_out),
    .link_id_in                 (link_id_in),
    .ref_link_in                (ref_link_in),
    .frame_loss_defect_in       (frame_loss_defect_in),
    .delineation_loss_defect_in (delineation_loss_defect_in),
    .frame_len_in               (frame_len_in),
    .frame_state_in             (frame_state_in),
    .delin_state_in             (delin_state_in),
    .frame_sync_in              (frame_sync_in),
    .delin_sync_in              (delin_sync_in)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and closing report.
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus cycles and link patterns.
  // ----------------------------------------------------------------
  function automatic logic [11:0] adr(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [9:0] idx,
                     input logic [31:0] exp);
    apb(1'b0, adr(idx), 32'h0000_0000);
    check(nm, rd, exp);
    check({nm, " err"}, {31'h0, er}, 32'h0000_0000);
  endtask

  function automatic logic [31:0] exp_lid(input logic [3:0] m);
    return {24'h0, m[0], m[1], m == 4'h5, 5'(m * 7 + 3)};
  endfunction

  // A raw delineation code of 11 must be shown as hunt.
  function automatic logic [31:0] exp_st(input logic [3:0] m);
    logic [1:0] d;
    d = (m[2:1] == 2'b11) ? 2'b00 : m[2:1];
    return {26'h0, m[3:2], m[1:0], d};
  endfunction

  // Link n carries pattern n xor salt on every per-link snapshot input; the sync inputs are left alone.
  task automatic set_links(input logic [3:0] salt);
    logic [3:0] m;
    @(posedge clk_in);
    for (int n = 0; n < 16; n++) begin
      m = 4'(n) ^ salt;
      link_id_in[5*n +: 5]          <= 5'(m * 7 + 3);
      ref_link_in[n]                <= (m == 4'h5);
      frame_loss_defect_in[n]       <= m[0];
      delineation_loss_defect_in[n] <= m[1];
      frame_len_in[2*n +: 2]        <= m[3:2];
      frame_state_in[2*n +: 2]      <= m[1:0];
      delin_state_in[2*n +: 2]      <= m[2:1];
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc("lid rst", `RLS_IDX_LID, 32'h0000_0020);
    rdc("st rst", `RLS_IDX_STATE, 32'h0000_0000);
  endtask

  // Every link, so every frame and delineation code is shown.
  task automatic t_snap();
    set_links(4'h0);
    for (int n = 0; n < 16; n++) begin
      apb(1'b1, adr(`RLS_IDX_LSEL), 32'(n));
      rdc("lid", `RLS_IDX_LID, exp_lid(4'(n)));
      rdc("st", `RLS_IDX_STATE, exp_st(4'(n)));
    end
  endtask

  // Inputs move and other writes land, yet snapshots hold.
  task automatic t_hold();
    apb(1'b1, adr(`RLS_IDX_LSEL), 32'h0000_0009);
    set_links(4'hF);
    rdc("lid hold", `RLS_IDX_LID, exp_lid(4'h9));
    apb(1'b1, adr(`RLS_IDX_LID), 32'h0000_FFFF);
    rdc("lid ro", `RLS_IDX_LID, exp_lid(4'h9));
    rdc("st hold", `RLS_IDX_STATE, exp_st(4'h9));
    apb(1'b1, adr(`RLS_IDX_LSEL), 32'h0000_0009);
    rdc("lid new", `RLS_IDX_LID, exp_lid(4'h6));
  endtask

  task automatic t_live();
    @(posedge clk_in);
    frame_sync_in <= 16'hA5C3;
    delin_sync_in <= 16'h3C5A;
    rdc("fsync", `RLS_IDX_FSYNC, 32'h0000_A5C3);
    rdc("dsync", `RLS_IDX_DSYNC, 32'h0000_3C5A);
    @(posedge clk_in);
    frame_sync_in <= 16'h5A3C;
    delin_sync_in <= 16'hC3A5;
    rdc("fsync", `RLS_IDX_FSYNC, 32'h0000_5A3C);
    rdc("dsync", `RLS_IDX_DSYNC, 32'h0000_C3A5);
    rdc("lid after", `RLS_IDX_LID, exp_lid(4'h6));
  endtask

  // Unmapped and unaligned reads fail without touching state.
  task automatic t_err();
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("unmapped err", {31'h0, er}, 32'h0000_0001);
    apb(1'b0, adr(`RLS_IDX_LID) + 12'h001, 32'h0000_0000);
    check("unaligned err", {31'h0, er}, 32'h0000_0001);
    rdc("lid kept", `RLS_IDX_LID, exp_lid(4'h6));
  endtask

  task automatic t_irq();
    apb(1'b1, adr(`RLS_IDX_ISTAT), 32'h0000_0007);
    rdc("istat clr", `RLS_IDX_ISTAT, 32'h0000_0000);
    apb(1'b1, adr(`RLS_IDX_IMASK), 32'h0000_0001);
    rdc("imask", `RLS_IDX_IMASK, 32'h0000_0001);
    apb(1'b1, adr(`RLS_IDX_LSEL), 32'h0000_0002);
    repeat (2) @(posedge clk_in);
    check("irq load", {31'h0, irq_out}, 32'h0000_0001);
    rdc("istat load", `RLS_IDX_ISTAT, 32'h0000_0001);
    apb(1'b1, adr(`RLS_IDX_ISTAT), 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    check("irq w1c", {31'h0, irq_out}, 32'h0000_0000);
    frame_sync_in <= 16'h0001;
    delin_sync_in <= 16'h0001;
    repeat (3) @(posedge clk_in);
    check("irq masked", {31'h0, irq_out}, 32'h0000_0000);
    rdc("istat sync", `RLS_IDX_ISTAT, 32'h0000_0006);
    apb(1'b1, adr(`RLS_IDX_IMASK), 32'h0000_0002);
    repeat (2) @(posedge clk_in);
    check("irq sync", {31'h0, irq_out}, 32'h0000_0001);
  endtask

  // A low enable stalls the bus and holds every flag as it was.
  task automatic t_freeze();
    @(posedge clk_in);
    ce_in         <= 1'b0;
    frame_sync_in <= 16'h0000;
    repeat (2) @(posedge clk_in);
    check("rdy frz", {31'h0, pready_out}, 32'h0000_0000);
    check("irq frz", {31'h0, irq_out}, 32'h0000_0001);
    ce_in <= 1'b1;
    rdc("istat thaw", `RLS_IDX_ISTAT, 32'h0000_0006);
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    rst_n_in                   = 1'b0;
    ce_in                      = 1'b1;
    psel_in                    = 1'b0;
    penable_in                 = 1'b0;
    pwrite_in                  = 1'b0;
    paddr_in                   = 12'h000;
    pwdata_in                  = 32'h0000_0000;
    link_id_in                 = '0;
    ref_link_in                = 16'h0000;
    frame_loss_defect_in       = 16'h0000;
    delineation_loss_defect_in = 16'h0000;
    frame_len_in               = 32'h0000_0000;
    frame_state_in             = 32'h0000_0000;
    delin_state_in             = 32'h0000_0000;
    frame_sync_in              = 16'h0000;
    delin_sync_in              = 16'h0000;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_snap();
    t_hold();
    t_live();
    t_err();
    t_irq();
    t_freeze();
    stop_test();
  end

endmodule
